// ---- rtl/bss_pkg.sv ----
// constants and types of the boot start select block
// Operation
// [RULE_01] status flag byte sampled once, at reset falling edge, chooses start
// [RULE_02] flag zero and no strap: fetch starts at 0000H
// [RULE_03] flag nonzero: start = vector byte as high byte, low byte 00H
// [RULE_04] shipped vector is 0FCH, forced boot lands at 0FC00H loader
// [RULE_05] erasing flag byte or vector byte clears both together
// [RULE_06] strobe low, P2.7/P2.6 high, access select high, ALE high force loader
// [RULE_07] enabled loader ROM replaces flash fetches in FC00..FFFF
// [RULE_08] loader ROM off: top 1 kbyte fetches return flash
// [RULE_09] five erase blocks: two 8k below 4000, three 16k above
// [RULE_10] self-programming code must run from another block than target
// [RULE_11] chip erase clears all flash, block erase only one block
// [RULE_12] access select low disables internal memory, all fetches external
// [RULE_13] flash byte wide; byte program takes about 20 us internally timed
// [RULE_14] programming agent should write zero to flag byte afterwards
// [RULE_15] changed vector no longer reaches built-in loader
// [RULE_16] start address latched at reset edge, held until next reset
package bss_pkg;
  localparam logic [31:0] BSS_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] BSS_STAT_ADDR = 32'h0000_0004;
  localparam logic [31:0] BSS_CMD_ADDR = 32'h0000_0008;
  localparam logic [31:0] BSS_BOOT_ADDR = 32'h0000_000C;
  localparam logic [31:0] BSS_FLASH_ADDR = 32'h0000_0010;
  localparam logic [7:0] BSS_VECTOR_RESET = 8'hFC;
  localparam logic [7:0] BSS_FLAG_RESET = 8'h00;
  localparam logic [7:0] BSS_ERASED = 8'hFF;
  localparam logic [7:0] BSS_LOW_ZERO = 8'h00;
  localparam logic [15:0] BSS_APP_START = 16'h0000;
  localparam logic [15:0] BSS_ROM_BASE = 16'hFC00;
  localparam logic [15:0] BSS_BLK2_BASE = 16'h4000;
  localparam int BSS_BLK_COUNT = 5;
  localparam int BSS_PROG_NS = 20000;
  localparam int BSS_CLK_NS = 50;
  localparam int BSS_PROG_CYC = (BSS_PROG_NS + BSS_CLK_NS - 1) / BSS_CLK_NS;
  localparam logic [1:0] BSS_CMD_PROG = 2'h1;
  localparam logic [1:0] BSS_CMD_BLOCK = 2'h2;
  localparam logic [1:0] BSS_CMD_CHIP = 2'h3;
  localparam int BSS_CTRL_ROM_BIT = 0;
  localparam int BSS_CTRL_SEL_BIT = 1;
  localparam int BSS_BOOT_ERASE_BIT = 9;
  localparam int BSS_BOOT_VEC_BIT = 8;
  localparam logic [1:0] BSS_RESP_OKAY = 2'b00;
  localparam logic [1:0] BSS_RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic strobe_n;
    logic p2_7;
    logic p2_6;
    logic access_sel;
    logic ale;
  } bss_strap_type;
  typedef enum logic [1:0] {
    BSS_SEL_FLAG,
    BSS_SEL_VECTOR,
    BSS_SEL_BOTH
  } bss_erase_sel_type;
endpackage : bss_pkg

// ---- rtl/bss_top.sv ----
// boot start select: reset-edge start address, boot rom overlay, flash map
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bss_top
  import bss_pkg::*;
#(
  parameter int PROG_CYCLES = BSS_PROG_CYC,
  parameter int FLASH_WORDS = 65536
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic reset_pin_n,
  input wire bss_strap_type straps,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_req,
  input wire logic [7:0] ext_data,
  output logic [7:0] fetch_data,
  output logic fetch_valid,
  output logic fetch_external,
  output logic [15:0] start_addr,
  output logic start_valid,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // boot rom image; contents left zero, filled by a later mask option
  logic [7:0] rom_mem [0:1023];
  logic [7:0] flash_mem [0:FLASH_WORDS-1];
  initial begin
    for (int i = 0; i < 1024; i++) begin
      rom_mem[i] = 8'h00;
    end
  end

  // three-stage sync on pins; change counts when stages 2 and 3 agree
  logic [5:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  wire [5:0] pin_raw = {reset_pin_n, straps};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q <= '0;
    end else if (clk_en) begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < 6; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) pin_q[i] <= pin_s3_q[i];
      end
    end
  end
  wire rst_n_f = pin_q[5];
  bss_strap_type strap_f;
  assign strap_f = bss_strap_type'(pin_q[4:0]);
  logic rst_n_prev_q;
  wire rst_fall = rst_n_prev_q && !rst_n_f;

  // nonvolatile bytes: they survive aresetn, so no reset term
  // declaration values stand for the shipped contents; no second writer
  logic [7:0] flag_q = BSS_FLAG_RESET;
  logic [7:0] vector_q = BSS_VECTOR_RESET; // RULE_04

  wire force_strap = !strap_f.strobe_n && strap_f.p2_7 && strap_f.p2_6 &&
    strap_f.access_sel && strap_f.ale; // RULE_06
  wire forced = (flag_q != BSS_FLAG_RESET) || force_strap; // RULE_01
  wire [15:0] start_d = forced ? {vector_q, BSS_LOW_ZERO} : // RULE_03
    BSS_APP_START; // RULE_02
  logic ext_mode_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_n_prev_q <= 1'b0;
      start_addr <= BSS_APP_START;
      start_valid <= 1'b0;
      ext_mode_q <= 1'b0;
    end else if (clk_en) begin
      rst_n_prev_q <= rst_n_f;
      if (rst_fall) begin
        start_addr <= start_d; // RULE_16 RULE_15
        start_valid <= 1'b1;
        ext_mode_q <= !strap_f.access_sel;
      end
    end
  end

  // control register: rom enable; bit 1 is stored and read back but drives nothing
  logic [1:0] ctrl_q;
  wire rom_on = ctrl_q[BSS_CTRL_ROM_BIT];
  wire in_rom = fetch_addr >= BSS_ROM_BASE;
  wire [7:0] flash_rd = flash_mem[fetch_addr];
  wire [7:0] rom_rd = rom_mem[fetch_addr[9:0]];
  wire [7:0] int_rd = (rom_on && in_rom) ? rom_rd : flash_rd; // RULE_07 RULE_08
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_data <= 8'h00;
      fetch_valid <= 1'b0;
      fetch_external <= 1'b0;
    end else if (clk_en) begin
      fetch_valid <= fetch_req;
      fetch_external <= ext_mode_q;
      fetch_data <= ext_mode_q ? ext_data : int_rd; // RULE_12
    end
  end

  // erase block index of an address
  function automatic logic [2:0] blk_of(input logic [15:0] a);
    if (a < BSS_BLK2_BASE) blk_of = {2'b00, a[13]}; // RULE_09
    else blk_of = 3'(a[15:14] + 2'd1);
  endfunction : blk_of

  // flash engine: byte program timed, erases
  logic busy_q;
  logic [1:0] op_q;
  logic [15:0] op_addr_q;
  logic [7:0] op_data_q;
  logic [31:0] cnt_q;
  logic [7:0] bootsel_q;
  wire op_done = busy_q && (cnt_q == 32'(PROG_CYCLES - 1));

  // axi-lite slave, single outstanding write and read
  logic aw_hold_q, w_hold_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  wire do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire wr_ctrl = do_write && awaddr_q == BSS_CTRL_ADDR;
  wire wr_cmd = do_write && awaddr_q == BSS_CMD_ADDR;
  wire wr_boot = do_write && awaddr_q == BSS_BOOT_ADDR;
  wire wr_known = wr_ctrl || wr_cmd || wr_boot || awaddr_q == BSS_FLASH_ADDR;
  wire cmd_go = wr_cmd && !busy_q && wdata_q[1:0] != 2'b00;
  wire [1:0] cmd_op = wdata_q[1:0];
  wire [15:0] cmd_addr = wdata_q[23:8];
  wire [7:0] cmd_data = wdata_q[31:24];
  wire rd_ctrl = s_axi_araddr == BSS_CTRL_ADDR;
  wire rd_stat = s_axi_araddr == BSS_STAT_ADDR;
  wire rd_boot = s_axi_araddr == BSS_BOOT_ADDR;
  wire rd_flash = s_axi_araddr == BSS_FLASH_ADDR;
  wire rd_cmd = s_axi_araddr == BSS_CMD_ADDR;
  wire rd_known = rd_ctrl || rd_stat || rd_boot || rd_flash || rd_cmd;
  wire [31:0] rd_word = rd_ctrl ? {30'h0, ctrl_q} :
    rd_stat ? {13'h0, ext_mode_q, start_valid, busy_q, start_addr} :
    rd_boot ? {16'h0, vector_q, flag_q} :
    rd_flash ? {24'h0, flash_mem[op_addr_q]} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      op_q <= 2'b00;
      op_addr_q <= 16'h0000;
      op_data_q <= 8'h00;
      cnt_q <= '0;
      ctrl_q <= 2'b01;
    end else if (clk_en) begin
      if (wr_ctrl && wstrb_q[0]) ctrl_q <= wdata_q[1:0];
      if (cmd_go) begin
        busy_q <= 1'b1;
        op_q <= cmd_op;
        op_addr_q <= cmd_addr;
        op_data_q <= cmd_data;
        cnt_q <= '0;
      end else if (op_done) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 32'd1; // RULE_13
      end
    end
  end

  // flash array and boot bytes: no reset, they are nonvolatile
  always_ff @(posedge aclk) begin
    if (clk_en && op_done) begin
      if (op_q == BSS_CMD_PROG) begin
        flash_mem[op_addr_q] <= flash_mem[op_addr_q] & op_data_q; // RULE_13
      end else begin
        for (int i = 0; i < FLASH_WORDS; i++) begin
          if (op_q == BSS_CMD_CHIP ||
              blk_of(16'(i)) == blk_of(op_addr_q)) begin // RULE_11
            flash_mem[i] <= BSS_ERASED;
          end
        end
      end
    end
  end

  // boot bytes: one bit erases both, another picks vector or flag
  wire boot_erase = wdata_q[BSS_BOOT_ERASE_BIT];
  wire boot_to_vec = wdata_q[BSS_BOOT_VEC_BIT];
  always_ff @(posedge aclk) begin
    if (clk_en && wr_boot && !busy_q) begin
      if (boot_erase) begin
        // erased like any flash byte, so the vector must be rewritten
        flag_q <= BSS_ERASED; // RULE_05
        vector_q <= BSS_ERASED;
      end else if (wstrb_q[0]) begin
        if (boot_to_vec) vector_q <= wdata_q[7:0];
        else flag_q <= wdata_q[7:0]; // RULE_14
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BSS_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= BSS_RESP_OKAY;
      s_axi_rdata <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? BSS_RESP_OKAY : BSS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? BSS_RESP_OKAY : BSS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ready never waits on valid, and stays low while read data is unclaimed
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_pending = s_axi_rvalid && !s_axi_rready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !rd_take && !rd_pending;
    end
  end
endmodule : bss_top
`default_nettype wire

// ---- test/bss_fetch_model.sv ----
// processor fetch side model: issues fetches, serves external memory
`timescale 1ns/1ps
`default_nettype none
module bss_fetch_model (
  input wire logic aclk,
  input wire logic [7:0] fetch_data,
  input wire logic fetch_external,
  output logic [15:0] fetch_addr,
  output logic fetch_req,
  output logic [7:0] ext_data
);
  initial begin
    fetch_addr = 16'h0000;
    fetch_req = 1'b0;
  end
  // idle bus shows the inverse so a stale byte never passes for an answer
  assign ext_data = fetch_req ? fetch_addr[7:0] ^ 8'h5A :
                    ~(fetch_addr[7:0] ^ 8'h5A);
  // code runs from its own block; it never fetches a block under erase
  task automatic fetch(input logic [15:0] a, output logic [7:0] d,
                       output logic x);
    @(posedge aclk);
    fetch_addr <= a;
    fetch_req <= 1'b1;
    @(posedge aclk);
    fetch_req <= 1'b0;
    @(negedge aclk);
    d = fetch_data;
    x = fetch_external;
  endtask : fetch
endmodule : bss_fetch_model
`default_nettype wire

// ---- test/bss_top_assertions.sv ----
// port checker for the boot start select block
`timescale 1ns/1ps
`default_nettype none
module bss_top_assertions
  import bss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic reset_pin_n,
  input wire logic fetch_req,
  input wire logic fetch_valid,
  input wire logic [15:0] start_addr,
  input wire logic start_valid,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_FETCH_ANSWER: assert property (clk_en && fetch_req |=> fetch_valid)
    else $error("fetch not answered next cycle");
  AST_FETCH_ONLY: assert property (clk_en && !fetch_req |=> !fetch_valid)
    else $error("fetch answer without request");
  AST_START_LOW: assert property (start_valid |-> start_addr[7:0] == BSS_LOW_ZERO)
    else $error("start address low byte not zero");
  AST_START_HOLD: assert property (reset_pin_n [*8] ##1 start_valid
    |-> $stable(start_addr) && $stable(start_valid))
    else $error("start address moved without reset");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while read data pending");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready
    |-> ##[1:6] s_axi_bvalid)
    else $error("write response late");
  COV_FETCH: cover property (fetch_valid);
  COV_LOADER: cover property (start_valid && start_addr == BSS_ROM_BASE);
  COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == BSS_RESP_SLVERR);
endmodule : bss_top_assertions
bind bss_top bss_top_assertions u_chk (.*);
`default_nettype wire

// ---- test/boot_start_select_bench.sv ----
// self-checking bench for the boot start select block
`timescale 1ns/1ps
`default_nettype none
module boot_start_select_bench
  import bss_pkg::*;
;
  logic aclk, aresetn, clk_en, reset_pin_n;
  bss_strap_type straps;
  logic [15:0] fetch_addr, start_addr;
  logic fetch_req, fetch_valid, fetch_external, start_valid;
  logic [7:0] ext_data, fetch_data, d;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, x;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int mismatches, compares;
  localparam bss_strap_type IDLE = 5'h13;
  localparam bss_strap_type FORCE = 5'h0F;
  bss_top #(.PROG_CYCLES(4)) DUT (.*);
  bss_fetch_model u_fetch (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic stop_test(input logic bad);
    if (bad) mismatches++;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi(input logic w, input logic [31:0] a, input logic [31:0] v);
    int n;
    n = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 99) stop_test(1'b1);
    end while (!(w ? s_axi_bvalid : s_axi_rvalid));
    q = s_axi_rdata;
    r = w ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'b00;
    @(posedge aclk);
  endtask : axi
  // writes may start a timed flash cycle, so wait for busy to clear
  task automatic wt(input logic [31:0] a, input logic [31:0] v);
    int n;
    axi(1'b1, a, v);
    for (n = 0; n < 40; n++) begin
      axi(1'b0, BSS_STAT_ADDR, 32'h0000_0000);
      if (q[16] === 1'b0) break;
    end
    if (n == 40) stop_test(1'b1);
  endtask : wt
  task automatic pr(input logic [15:0] a, input logic [7:0] v);
    wt(BSS_CMD_ADDR, {v, a, 6'h00, BSS_CMD_PROG});
  endtask : pr
  // programming all ones leaves the byte as is but sets the read address
  task automatic fl(input logic [15:0] a);
    pr(a, 8'hFF);
    axi(1'b0, BSS_FLASH_ADDR, 32'h0000_0000);
  endtask : fl
  task automatic boot(input bss_strap_type s);
    straps <= s;
    repeat (2) @(posedge aclk);
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge aclk);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : boot
  task automatic t_reset;
    axi(1'b0, BSS_BOOT_ADDR, 32'h0000_0000);
    chk(q[15:0], {BSS_VECTOR_RESET, BSS_FLAG_RESET});
    axi(1'b0, BSS_CTRL_ADDR, 32'h0000_0000);
    chk(q[0], 1'b1);
    axi(1'b0, 32'h0000_0020, 32'h0000_0000);
    chk(r, BSS_RESP_SLVERR);
    boot(IDLE);
    chk({start_valid, start_addr}, {1'b1, BSS_APP_START});
    $display("test reset done");
  endtask : t_reset
  task automatic t_flash;
    wt(BSS_CMD_ADDR, {30'h0000_0000, BSS_CMD_CHIP});
    fl(16'hFBFF);
    chk(q[7:0], BSS_ERASED);
    pr(16'h3FFF, 8'h11);
    pr(16'h4000, 8'h22);
    pr(16'hFBFF, 8'hA5);
    pr(16'hFC10, 8'h3C);
    wt(BSS_CMD_ADDR, {8'h00, BSS_BLK2_BASE, 6'h00, BSS_CMD_BLOCK});
    fl(16'h3FFF);
    chk(q[7:0], 8'h11);
    fl(BSS_BLK2_BASE);
    chk(q[7:0], BSS_ERASED);
    u_fetch.fetch(16'hFBFF, d, x);
    chk({x, d}, {1'b0, 8'hA5});
    // blank boot rom image hides the 3C programmed underneath
    u_fetch.fetch(16'hFC10, d, x);
    chk({x, d}, {1'b0, 8'h00});
    wt(BSS_CTRL_ADDR, 32'h0000_0000);
    u_fetch.fetch(16'hFC10, d, x);
    chk({x, d}, {1'b0, 8'h3C});
    wt(BSS_CTRL_ADDR, 32'h0000_0001);
    $display("test flash done");
  endtask : t_flash
  task automatic t_flag;
    wt(BSS_BOOT_ADDR, 32'h0000_0200);
    axi(1'b0, BSS_BOOT_ADDR, 32'h0000_0000);
    chk(q[15:0], 16'hFFFF);
    boot(IDLE);
    chk(start_addr, 16'hFF00);
    wt(BSS_BOOT_ADDR, 32'h0000_01FC);
    boot(IDLE);
    chk(start_addr, BSS_ROM_BASE);
    wt(BSS_BOOT_ADDR, 32'h0000_0000);
    boot(IDLE);
    chk(start_addr, BSS_APP_START);
    straps <= FORCE;
    repeat (8) @(posedge aclk);
    chk(start_addr, BSS_APP_START);
    $display("test flag done");
  endtask : t_flag
  task automatic t_strap;
    boot(FORCE);
    chk(start_addr, BSS_ROM_BASE);
    boot(5'h0E);
    chk(start_addr, BSS_APP_START);
    boot(5'h11);
    u_fetch.fetch(16'h1234, d, x);
    chk({x, d}, {1'b1, 8'h6E});
    // with the clock enable low a forced reset pulse must leave no trace
    clk_en <= 1'b0;
    boot(FORCE);
    clk_en <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({start_valid, start_addr}, {1'b1, BSS_APP_START});
    $display("test strap done");
  endtask : t_strap
  initial begin
    {aresetn, clk_en, reset_pin_n, straps} = {3'b011, IDLE};
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h0F;
    {mismatches, compares} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_flash();
    t_flag();
    t_strap();
    stop_test(1'b0);
  end
endmodule : boot_start_select_bench
`default_nettype wire
